// ---- include/xid_consts.svh ----
`ifndef XID_CONSTS_SVH
`define XID_CONSTS_SVH
`define XID_OP_ARITH_HI 8'he8
`define XID_OP_SUB_HI 8'he9
`define XID_OP_PUSH_HI 8'hea
`define XID_OP_MOVS_HI 8'heb
`define XID_OP_CALL_THROUGH_WORK_REG 16'h0014
`define XID_SECOND_NIB 4'hf
`define XID_RET_SEL 2'h3
`define XID_SOFT_SP_SEL 2'h2
`define XID_ILO_MAX 8'h5f
`define XID_PTR_RST 12'h000
`define XID_NUM_EXT 4'h8
`endif

// ---- include/xid_pkg.sv ----
package xid_pkg;
  typedef enum logic [1:0] {
    XID_ST_FETCH = 2'b00,
    XID_ST_NOP = 2'b01,
    XID_ST_MOVE2 = 2'b10
  } xid_state_t;
  typedef struct packed {
    logic [11:0] ptr0;
    logic [11:0] ptr1;
    logic [11:0] ptr2;
  } xid_ptrs_t;
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } xid_wr_t;
  typedef struct packed {
    logic load;
    logic [20:0] value;
  } xid_pc_t;
  typedef struct packed {
    xid_state_t state;
    xid_ptrs_t ptrs;
    xid_wr_t wr;
    xid_pc_t pc;
    logic push;
    logic [20:0] push_val;
    logic pop;
    logic ext_hit;
    logic ilo;
    logic [11:0] ilo_addr;
    logic [7:0] move_src;
    logic move_to_stack;
    logic rd_req;
    logic [11:0] rd_addr;
  } xid_st_t;
endpackage : xid_pkg

// ---- core/xid_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "xid_consts.svh"
// Contract
// - Extension and indexed offset mode are off after reset and on only with the enable bit.
// - Exactly eight extra literal instructions are decoded.
// - Add-literal adds an unsigned 6-bit literal to pointer 0..2 in one cycle, no flags.
// - Pointer field 11 of add adds to the stack pointer and returns in two cycles.
// - Sub-literal subtracts the 6-bit literal from the selected pointer in one cycle.
// - Pointer field 11 of sub subtracts from the stack pointer and returns in two cycles.
// - Both add and sub have a stack pointer form with automatic return afterwards.
// - Call-through-work pushes the return address, loads pc from work and latches, two cycles.
// - Stack moves start e b, bit 7 picks file or stack destination, second word starts f.
// - Push-literal stores the byte at the stack pointer then decrements it, one cycle.
// - With extension on and access bit 0, file operands up to 95 use indexed offset mode.
module xid_decode (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic extension_enable_cfg_bit,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [20:0] pc_now,
  input wire logic [7:0] work_register,
  input wire logic [7:0] pc_latch_hi,
  input wire logic [4:0] pc_latch_up,
  input wire logic [20:0] return_stack_top,
  input wire logic [7:0] rd_data,
  output xid_pkg::xid_ptrs_t file_select_pointer,
  output xid_pkg::xid_wr_t mem_wr,
  output xid_pkg::xid_pc_t pc_load,
  output logic rs_push,
  output logic [20:0] rs_push_val,
  output logic rs_pop,
  output logic ext_hit,
  output logic ilo_active,
  output logic [11:0] ilo_addr,
  output logic rd_req,
  output logic [11:0] rd_addr,
  output logic stall
);
  xid_pkg::xid_st_t st_reg;
  xid_pkg::xid_st_t st_next;
  logic en_sync1_reg;
  logic en_sync2_reg;

  function automatic logic [11:0] sel_ptr(input xid_pkg::xid_ptrs_t p,
                                          input logic [1:0] s);
    if (s == 2'h0) begin
      sel_ptr = p.ptr0;
    end else if (s == 2'h1) begin
      sel_ptr = p.ptr1;
    end else begin
      sel_ptr = p.ptr2;
    end
  endfunction : sel_ptr

  function automatic xid_pkg::xid_ptrs_t put_ptr(input xid_pkg::xid_ptrs_t p,
                                                 input logic [1:0] s,
                                                 input logic [11:0] v);
    put_ptr = p;
    if (s == 2'h0) begin
      put_ptr.ptr0 = v;
    end else if (s == 2'h1) begin
      put_ptr.ptr1 = v;
    end else begin
      put_ptr.ptr2 = v;
    end
  endfunction : put_ptr

  ////////////////////////////////////////////////////////////////////////
  // config bit is a strap from outside, so synchronise before use
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en_sync1_reg <= 1'b0;
      en_sync2_reg <= 1'b0;
    end else begin
      en_sync1_reg <= extension_enable_cfg_bit;
      en_sync2_reg <= en_sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0] fsel;
    logic [5:0] k6;
    logic [11:0] cur;
    logic [11:0] sp;
    fsel = instr[7:6];
    k6 = instr[5:0];
    cur = 12'h000;
    sp = st_reg.ptrs.ptr2;
    st_next = st_reg;
    st_next.wr.we = 1'b0;
    st_next.pc.load = 1'b0;
    st_next.push = 1'b0;
    st_next.pop = 1'b0;
    st_next.ext_hit = 1'b0;
    st_next.ilo = 1'b0;
    st_next.rd_req = 1'b0;
    case (st_reg.state)
      xid_pkg::XID_ST_FETCH: begin
        if (instr_valid && en_sync2_reg) begin
          // eight opcodes: add, sub (each with return form), push, two
          // moves, call through work
          if (instr[15:8] == `XID_OP_ARITH_HI ||
              instr[15:8] == `XID_OP_SUB_HI) begin
            st_next.ext_hit = 1'b1;
            if (fsel == `XID_RET_SEL) begin
              cur = sp;
            end else begin
              cur = sel_ptr(st_reg.ptrs, fsel);
            end
            if (instr[8]) begin
              cur = cur - {6'h00, k6};
            end else begin
              cur = cur + {6'h00, k6};
            end
            if (fsel == `XID_RET_SEL) begin
              // return form: arithmetic and pop registered in the same cycle
              st_next.ptrs.ptr2 = cur;
              st_next.pop = 1'b1;
              st_next.pc.load = 1'b1;
              st_next.pc.value = return_stack_top;
              st_next.state = xid_pkg::XID_ST_NOP;
            end else begin
              st_next.ptrs = put_ptr(st_reg.ptrs, fsel, cur);
            end
          end else if (instr[15:8] == `XID_OP_PUSH_HI) begin
            st_next.ext_hit = 1'b1;
            st_next.wr.we = 1'b1;
            st_next.wr.addr = sp;
            st_next.wr.data = instr[7:0];
            st_next.ptrs.ptr2 = sp - 12'h001;
          end else if (instr[15:8] == `XID_OP_MOVS_HI) begin
            st_next.ext_hit = 1'b1;
            st_next.rd_req = 1'b1;
            st_next.rd_addr = sp + {5'h00, instr[6:0]};
            st_next.move_to_stack = instr[7];
            st_next.state = xid_pkg::XID_ST_MOVE2;
          end else if (instr == `XID_OP_CALL_THROUGH_WORK_REG) begin
            st_next.ext_hit = 1'b1;
            st_next.push = 1'b1;
            st_next.push_val = pc_now + 21'h000002;
            st_next.pc.load = 1'b1;
            st_next.pc.value = {pc_latch_up, pc_latch_hi, work_register};
            st_next.state = xid_pkg::XID_ST_NOP;
          end else if (!instr[8] && instr[7:0] <= `XID_ILO_MAX &&
                       instr[15:12] != 4'he && instr[15:12] != 4'hf &&
                       instr[15:12] != 4'h0) begin
            // byte ops with access bit 0 and low operand
            st_next.ilo = 1'b1;
            st_next.ilo_addr = sp + {4'h0, instr[7:0]};
          end
        end
      end
      xid_pkg::XID_ST_NOP: begin
        // fetch of new target in flight, do nothing
        st_next.state = xid_pkg::XID_ST_FETCH;
      end
      xid_pkg::XID_ST_MOVE2: begin
        // second word: destination; corrupt second word just ends
        if (instr_valid) begin
          if (instr[15:12] == `XID_SECOND_NIB) begin
            st_next.wr.we = 1'b1;
            st_next.wr.data = rd_data;
            if (st_reg.move_to_stack) begin
              st_next.wr.addr = sp + {5'h00, instr[6:0]};
            end else begin
              st_next.wr.addr = instr[11:0];
            end
          end
          st_next.state = xid_pkg::XID_ST_FETCH;
        end
      end
      default: begin
        st_next.state = xid_pkg::XID_ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops
  assign file_select_pointer = st_reg.ptrs;
  assign mem_wr = st_reg.wr;
  assign pc_load = st_reg.pc;
  assign rs_push = st_reg.push;
  assign rs_push_val = st_reg.push_val;
  assign rs_pop = st_reg.pop;
  assign ext_hit = st_reg.ext_hit;
  assign ilo_active = st_reg.ilo;
  assign ilo_addr = st_reg.ilo_addr;
  assign rd_req = st_reg.rd_req;
  assign rd_addr = st_reg.rd_addr;
  assign stall = (st_reg.state != xid_pkg::XID_ST_FETCH);
endmodule : xid_decode
`default_nettype wire

// ---- verification/xid_decode_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module xid_decode_properties (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic extension_enable_cfg_bit,
  input wire logic [15:0] instr,
  input wire logic [20:0] pc_now,
  input wire logic [20:0] return_stack_top,
  input wire xid_pkg::xid_ptrs_t file_select_pointer,
  input wire xid_pkg::xid_wr_t mem_wr,
  input wire xid_pkg::xid_pc_t pc_load,
  input wire logic rs_push,
  input wire logic [20:0] rs_push_val,
  input wire logic rs_pop,
  input wire logic ext_hit,
  input wire logic rd_req,
  input wire logic [11:0] rd_addr,
  input wire logic stall
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  property p_add;
    ext_hit && $past(instr[15:6]) == {8'he8, 2'h1} |->
      file_select_pointer.ptr1 == $past(file_select_pointer.ptr1) +
      {6'h0, $past(instr[5:0])};
  endproperty
  a_add: assert property (p_add) else $error("add wrong");
  property p_sub;
    ext_hit && $past(instr[15:6]) == {8'he9, 2'h0} |->
      file_select_pointer.ptr0 == $past(file_select_pointer.ptr0) -
      {6'h0, $past(instr[5:0])};
  endproperty
  a_sub: assert property (p_sub) else $error("sub wrong");
  property p_ret;
    ext_hit && $past(instr[15:9]) == 7'h74 && $past(instr[7:6]) == 2'h3
      |-> rs_pop && pc_load.load && pc_load.value == $past(return_stack_top);
  endproperty
  a_ret: assert property (p_ret) else $error("ret wrong");
  property p_nop;
    rs_pop |=> !stall && !ext_hit && !mem_wr.we;
  endproperty
  a_nop: assert property (p_nop) else $error("nop wrong");
  property p_call;
    ext_hit && $past(instr) == 16'h0014 |->
      rs_push && stall && rs_push_val == $past(pc_now) + 21'h2;
  endproperty
  a_call: assert property (p_call) else $error("call wrong");
  property p_push;
    ext_hit && $past(instr[15:8]) == 8'hea |-> mem_wr.we &&
      mem_wr.addr == $past(file_select_pointer.ptr2) &&
      file_select_pointer.ptr2 == $past(file_select_pointer.ptr2) - 12'h1;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_move;
    ext_hit && $past(instr[15:8]) == 8'heb |-> rd_req && stall &&
      rd_addr == file_select_pointer.ptr2 + {5'h0, $past(instr[6:0])};
  endproperty
  a_move: assert property (p_move) else $error("move wrong");
  property p_off;
    !extension_enable_cfg_bit [*4] |=> !ext_hit;
  endproperty
  a_off: assert property (p_off) else $error("decode while off");
endmodule : xid_decode_properties
bind xid_decode xid_decode_properties i_chk (
  .mclk(mclk),
  .nrst(nrst),
  .extension_enable_cfg_bit(extension_enable_cfg_bit),
  .instr(instr),
  .pc_now(pc_now),
  .return_stack_top(return_stack_top),
  .file_select_pointer(file_select_pointer),
  .mem_wr(mem_wr),
  .pc_load(pc_load),
  .rs_push(rs_push),
  .rs_push_val(rs_push_val),
  .rs_pop(rs_pop),
  .ext_hit(ext_hit),
  .rd_req(rd_req),
  .rd_addr(rd_addr),
  .stall(stall)
);
`default_nettype wire

// ---- verification/extended_literal_instr_decode_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module extended_literal_instr_decode_tb_top;
  logic mclk = 1'b0, nrst = 1'b0, extension_enable_cfg_bit = 1'b1;
  logic instr_valid = 1'b0, rs_push, rs_pop, ext_hit, ilo_active;
  logic rd_req, stall;
  logic [15:0] instr = 16'h0;
  logic [20:0] pc_now = 21'h100, return_stack_top = 21'h1234, rs_push_val;
  logic [7:0] work_register = 8'h9a, pc_latch_hi = 8'h34, rd_data = 8'h5a;
  logic [4:0] pc_latch_up = 5'h12;
  logic [11:0] ilo_addr, rd_addr;
  xid_pkg::xid_ptrs_t file_select_pointer;
  xid_pkg::xid_wr_t mem_wr;
  xid_pkg::xid_pc_t pc_load;
  int n_fail = 0, checked = 0;
  logic [51:0] rows [8] = '{{16'he845, 36'h000005000},
    {16'he83f, 36'h03f005000}, {16'he902, 36'h03d005000},
    {16'he8a1, 36'h03d005021}, {16'he8c3, 36'h03d005024},
    {16'he9c1, 36'h03d005023}, {16'he962, 36'h03dfe3023},
    {16'hea7a, 36'h03dfe3022}};
  xid_decode i_xid_decode (
    .mclk(mclk),
    .nrst(nrst),
    .extension_enable_cfg_bit(extension_enable_cfg_bit),
    .instr_valid(instr_valid),
    .instr(instr),
    .pc_now(pc_now),
    .work_register(work_register),
    .pc_latch_hi(pc_latch_hi),
    .pc_latch_up(pc_latch_up),
    .return_stack_top(return_stack_top),
    .rd_data(rd_data),
    .file_select_pointer(file_select_pointer),
    .mem_wr(mem_wr),
    .pc_load(pc_load),
    .rs_push(rs_push),
    .rs_push_val(rs_push_val),
    .rs_pop(rs_pop),
    .ext_hit(ext_hit),
    .ilo_active(ilo_active),
    .ilo_addr(ilo_addr),
    .rd_req(rd_req),
    .rd_addr(rd_addr),
    .stall(stall)
  );
  initial forever #20 mclk = ~mclk;
  ////////////////////////////////////////
  task close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task chk_p(input logic [35:0] e);
    chk({28'h0, file_select_pointer}, {28'h0, e});
  endtask : chk_p
  task idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  // pulses are sampled just after the edge that answers the word
  task op(input logic [15:0] w);
    @(posedge mclk);
    instr <= w;
    instr_valid <= 1'b1;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
  endtask : op
  ////////////////////////////////////////
  initial begin
    idle(8);
    nrst <= 1'b1;
    idle(3);
    chk_p(36'h0);
    foreach (rows[i]) begin
      op(rows[i][51:36]);
      idle(2);
      chk_p(rows[i][35:0]);
    end
    op(16'hea10);
    chk(mem_wr, {1'b1, 12'h022, 8'h10});
    idle(2);
    op(16'he8c0);
    chk({rs_pop, stall, pc_load}, {3'h7, 21'h1234});
    idle(2);
    op(16'h0014);
    chk({rs_push, rs_push_val, pc_load},
        {1'b1, 21'h102, 1'b1, 5'h12, 8'h34, 8'h9a});
    idle(2);
    op(16'heb05);
    chk({rd_req, stall, rd_addr}, {2'h3, 12'h026});
    op(16'hf123);
    chk(mem_wr, {1'b1, 12'h123, 8'h5a});
    idle(2);
    // byte op, access bit 0, operand 10 at or below the limit
    op(16'h2410);
    chk({ilo_active, ilo_addr}, {1'b1, 12'h031});
    // operand 60 lies above the limit, so no indexed mode
    op(16'h2460);
    chk(ilo_active, 1'b0);
    idle(2);
    nrst <= 1'b0;
    extension_enable_cfg_bit <= 1'b0;
    idle(8);
    nrst <= 1'b1;
    idle(3);
    op(16'he845);
    chk({ext_hit, file_select_pointer}, 37'h0);
    close_out();
  end
  initial begin
    idle(1000);
    n_fail++;
    close_out();
  end
endmodule : extended_literal_instr_decode_tb_top
`default_nettype wire
